// ### verilog/hrfp_dev.sv
// Device end: host register and queue port behind the 16-bit bus.
module hrfp_dev
    import hrfp_pkg::*;
#(
    parameter int         AW     = 4,
    // Identification value is arbitrary.
    parameter hrfp_word_t ID_VAL = 32'h0000_0A5C
) (
    input  wire logic       clk,
    input  wire logic       ce,
    input  wire logic       sys_rst,
    hrfp_if.dev             hb,
    input  wire logic       rxs_valid,
    input  wire hrfp_word_t rxs_data,
    output logic            rxs_ready,
    input  wire logic       rxd_valid,
    input  wire hrfp_word_t rxd_data,
    output logic            rxd_ready,
    input  wire logic       txs_valid,
    input  wire hrfp_word_t txs_data,
    output logic            txs_ready,
    output logic            txd_valid,
    output hrfp_word_t      txd_data,
    input  wire logic       txd_ready,
    input  wire logic       link_ok,
    input  wire logic       fault,
    input  wire logic       err_evt,
    input  wire logic       rx_drop,
    output logic            soft_rst,
    output logic [7:0]      ctrl_imm,
    output logic [7:0]      ctrl_gen
);
    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic       rd_lo;
    logic       rd_hi;
    logic       wr_lo;
    logic       wr_hi;
    hrfp_addr_t dw;
    logic       is_rxd;
    logic       is_txd;
    hrfp_word_t wword;
    hrfp_half_t wlo_r;
    hrfp_word_t hold_r;
    hrfp_word_t rd_word;
    hrfp_half_t rdata_r;
    logic       rvalid_r;

    // [R1] half transfers
    assign rd_lo  = ce && hb.hb_rd && !hb.hb_addr[`HRFP_HALF_BIT];
    assign rd_hi  = ce && hb.hb_rd && hb.hb_addr[`HRFP_HALF_BIT];
    assign wr_lo  = ce && hb.hb_wr && !hb.hb_addr[`HRFP_HALF_BIT];
    assign wr_hi  = ce && hb.hb_wr && hb.hb_addr[`HRFP_HALF_BIT];
    assign dw     = {hb.hb_addr[7:2], 2'b00};
    // [R17] receive data alias
    assign is_rxd = hb.hb_addr[`HRFP_SEL_HI:`HRFP_SEL_LO] == `HRFP_SEL_RXD;
    // [R20] transmit data alias
    assign is_txd = hb.hb_addr[`HRFP_SEL_HI:`HRFP_SEL_LO] == `HRFP_SEL_TXD;
    // [R2] pair halves
    assign wword  = {hb.hb_wdata, wlo_r};

    // ----------------------------------------------------------------
    // Control, status and size registers
    // ----------------------------------------------------------------
    logic       srst_r;
    logic [7:0] imm_r;
    logic [7:0] gen_r;
    logic       err_r;
    logic       link_r;
    logic       fault_r;
    logic [15:0] drop_r;
    hrfp_word_t size_r;
    logic       any_rst;
    logic       ctrl_wr;
    logic       stat_wr;
    logic       stat_rd;

    assign any_rst = sys_rst || (ce && srst_r);
    assign ctrl_wr = wr_hi && (dw == `HRFP_A_CTRL);
    assign stat_wr = wr_hi && (dw == `HRFP_A_STAT);
    assign stat_rd = rd_hi && (dw == `HRFP_A_STAT);
    assign soft_rst = srst_r;
    assign ctrl_imm = imm_r;
    assign ctrl_gen = gen_r;

    // [R21] self-clearing reset bit
    always_ff @(posedge clk) begin
        if (any_rst) begin
            srst_r <= 1'b0;
        end else if (ctrl_wr) begin
            srst_r <= wword[`HRFP_CTRL_SRST];
        end
    end

    // [R8] immune to soft reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            imm_r <= '0;
        end else if (ctrl_wr) begin
            imm_r <= wword[`HRFP_CTRL_IMM_MSB:`HRFP_CTRL_IMM_LSB];
        end
    end

    // [R11] defaults on reset
    always_ff @(posedge clk) begin
        if (any_rst) begin
            gen_r <= '0;
        end else if (ctrl_wr) begin
            gen_r <= wword[`HRFP_CTRL_GEN_MSB:`HRFP_CTRL_GEN_LSB];
        end
    end

    // [R5] write one clears
    always_ff @(posedge clk) begin
        if (any_rst) begin
            err_r <= 1'b0;
        end else if (ce) begin
            if (err_evt) begin
                err_r <= 1'b1;
            end else if (stat_wr && wword[`HRFP_STAT_ERR]) begin
                err_r <= 1'b0;
            end
        end
    end

    // [R7] latch low and high
    always_ff @(posedge clk) begin
        if (any_rst) begin
            link_r  <= 1'b1;
            fault_r <= 1'b0;
        end else if (ce) begin
            if (stat_rd) begin
                link_r  <= link_ok;
                fault_r <= fault;
            end else begin
                link_r  <= link_r && link_ok;
                fault_r <= fault_r || fault;
            end
        end
    end

    // [R6] clear on read
    always_ff @(posedge clk) begin
        if (any_rst) begin
            drop_r <= '0;
        end else if (ce) begin
            if (stat_rd) begin
                drop_r <= {15'h0000, rx_drop};
            end else if (rx_drop && (drop_r != 16'hFFFF)) begin
                drop_r <= drop_r + 16'h0001;
            end
        end
    end

    // [R12] queue sizes
    always_ff @(posedge clk) begin
        if (any_rst) begin
            size_r <= `HRFP_SIZE_RST;
        end else if (wr_hi && (dw == `HRFP_A_SIZE)) begin
            size_r <= wword & `HRFP_SIZE_MASK;
        end
    end

    // ----------------------------------------------------------------
    // Queues
    // ----------------------------------------------------------------
    hrfp_word_t rxs_head;
    hrfp_word_t rxd_head;
    hrfp_word_t txs_head;
    logic       rxs_empty;
    logic       rxd_empty;
    logic       txs_empty;
    logic       txd_empty;
    logic       rxs_full;
    logic       rxd_full;
    logic       txs_full;
    logic       txd_full;
    logic       rxs_pop;
    logic       rxd_pop;
    logic       txs_pop;
    logic       txd_push;

    // [R14] pop receive status
    assign rxs_pop  = rd_hi && (dw == `HRFP_A_RXS_POP);
    // [R16] pop receive data
    assign rxd_pop  = rd_hi && is_rxd;
    // [R18] pop transmit status
    assign txs_pop  = rd_hi && (dw == `HRFP_A_TXS_POP);
    // [R13] [R22] tx push, second half
    assign txd_push = wr_hi && is_txd;
    assign rxs_ready = !rxs_full;
    assign rxd_ready = !rxd_full;
    assign txs_ready = !txs_full;
    assign txd_valid = !txd_empty;

    hrfp_fifo #(.W(32), .AW(AW)) u_rxs (
        .clk     (clk),
        .ce      (ce),
        .sys_rst (sys_rst),
        .flush   (srst_r),
        .limit   (size_r[`HRFP_SIZE_RXS_LSB +: AW+1]),
        .push    (rxs_valid),
        .din     (rxs_data),
        .pop     (rxs_pop),
        .head    (rxs_head),
        .empty   (rxs_empty),
        .full    (rxs_full)
    );

    hrfp_fifo #(.W(32), .AW(AW)) u_rxd (
        .clk     (clk),
        .ce      (ce),
        .sys_rst (sys_rst),
        .flush   (srst_r),
        .limit   (size_r[`HRFP_SIZE_RXD_LSB +: AW+1]),
        .push    (rxd_valid),
        .din     (rxd_data),
        .pop     (rxd_pop),
        .head    (rxd_head),
        .empty   (rxd_empty),
        .full    (rxd_full)
    );

    hrfp_fifo #(.W(32), .AW(AW)) u_txs (
        .clk     (clk),
        .ce      (ce),
        .sys_rst (sys_rst),
        .flush   (srst_r),
        .limit   ((AW+1)'(2**AW)),
        .push    (txs_valid),
        .din     (txs_data),
        .pop     (txs_pop),
        .head    (txs_head),
        .empty   (txs_empty),
        .full    (txs_full)
    );

    hrfp_fifo #(.W(32), .AW(AW)) u_txd (
        .clk     (clk),
        .ce      (ce),
        .sys_rst (sys_rst),
        .flush   (srst_r),
        .limit   (size_r[`HRFP_SIZE_TXD_LSB +: AW+1]),
        .push    (txd_push),
        .din     (wword),
        .pop     (txd_ready),
        .head    (txd_data),
        .empty   (txd_empty),
        .full    (txd_full)
    );

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Empty queues and write-only or reserved locations read as zero.
    always_comb begin
        rd_word = `HRFP_ZERO_WORD;
        if (is_rxd) begin
            rd_word = rxd_empty ? `HRFP_ZERO_WORD : rxd_head;
        end else if (is_txd) begin
            // [R4] write-only reads zero
            rd_word = `HRFP_ZERO_WORD;
        end else begin
            case (dw)
                // [R15] inspect without pop
                `HRFP_A_RXS_POP,
                `HRFP_A_RXS_INSP: begin
                    rd_word = rxs_empty ? `HRFP_ZERO_WORD : rxs_head;
                end
                // [R19] inspect without pop
                `HRFP_A_TXS_POP,
                `HRFP_A_TXS_INSP: begin
                    rd_word = txs_empty ? `HRFP_ZERO_WORD : txs_head;
                end
                `HRFP_A_CTRL: begin
                    rd_word[`HRFP_CTRL_SRST] = srst_r;
                    rd_word[`HRFP_CTRL_IMM_MSB:`HRFP_CTRL_IMM_LSB] = imm_r;
                    rd_word[`HRFP_CTRL_GEN_MSB:`HRFP_CTRL_GEN_LSB] = gen_r;
                end
                `HRFP_A_STAT: begin
                    rd_word[`HRFP_STAT_ERR]   = err_r;
                    rd_word[`HRFP_STAT_LINK]  = link_r;
                    rd_word[`HRFP_STAT_FAULT] = fault_r;
                    rd_word[`HRFP_STAT_DRP_MSB:`HRFP_STAT_DRP_LSB] = drop_r;
                end
                // [R3] read-only identity
                `HRFP_A_ID:   rd_word = ID_VAL;
                `HRFP_A_SIZE: rd_word = size_r;
                default:      rd_word = `HRFP_ZERO_WORD;
            endcase
        end
    end

    // [R2] snapshot whole word
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hold_r <= '0;
            wlo_r  <= '0;
        end else begin
            if (rd_lo) begin
                hold_r <= rd_word;
            end
            if (wr_lo) begin
                wlo_r <= hb.hb_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
        end else if (ce) begin
            rvalid_r <= rd_lo || rd_hi;
            if (rd_lo) begin
                rdata_r <= rd_word[15:0];
            end else if (rd_hi) begin
                rdata_r <= hold_r[31:16];
            end
        end
    end

    assign hb.hb_rdata  = rdata_r;
    assign hb.hb_rvalid = rvalid_r;
endmodule

// ### verilog/hrfp_defines.svh
// Address map, field positions and reset values of the host port.
// Functional notes
// [R1] Sixteen-bit host bus, thirty-two-bit internal words.
// [R2] Two halves form one atomic access.
// [R3] Writes to read-only registers are ignored.
// [R4] Write-only locations read as zero.
// [R5] Writing one clears bit; zero keeps.
// [R6] Clear-on-read bits clear when read.
// [R7] Latched status holds until register read.
// [R8] Immune fields survive software reset.
// [R9] Host writes zeros to reserved bits.
// [R10] Host never writes reserved registers.
// [R11] Every reset loads register defaults; soft reset leaves imm_r unchanged.
// [R12] Four queues; three sizes set by registers.
// [R13] Receive queues are read-only to host.
// [R14] Receive status pop returns and removes head.
// [R15] Receive status inspect returns head only.
// [R16] Receive data read returns, removes head.
// [R17] Receive data aliased over sixteen dwords.
// [R18] Transmit status pop returns, removes head.
// [R19] Transmit status inspect leaves queue unchanged.
// [R20] Transmit data write-only, sixteen aliased dwords.
// [R21] Self-clearing bits return to zero automatically.
// [R22] Pop or push once, on second half.
`ifndef HRFP_DEFINES_SVH
`define HRFP_DEFINES_SVH

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
`define HRFP_HALF_BIT     1
`define HRFP_SEL_HI       7
`define HRFP_SEL_LO       6
`define HRFP_SEL_RXD      2'h0
`define HRFP_SEL_TXD      2'h1
`define HRFP_A_RXS_POP    8'h80
`define HRFP_A_RXS_INSP   8'h84
`define HRFP_A_TXS_POP    8'h88
`define HRFP_A_TXS_INSP   8'h8C
`define HRFP_A_CTRL       8'h90
`define HRFP_A_STAT       8'h94
`define HRFP_A_ID         8'h98
`define HRFP_A_SIZE       8'h9C
`define HRFP_A_LAST       8'h9C

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define HRFP_CTRL_SRST    0
`define HRFP_CTRL_IMM_LSB 8
`define HRFP_CTRL_IMM_MSB 15
`define HRFP_CTRL_GEN_LSB 16
`define HRFP_CTRL_GEN_MSB 23
`define HRFP_CTRL_MASK    32'h00FF_FF01
`define HRFP_STAT_ERR     0
`define HRFP_STAT_LINK    1
`define HRFP_STAT_FAULT   2
`define HRFP_STAT_DRP_LSB 16
`define HRFP_STAT_DRP_MSB 31
`define HRFP_STAT_MASK    32'h0000_0001
`define HRFP_SIZE_RXD_LSB 0
`define HRFP_SIZE_TXD_LSB 8
`define HRFP_SIZE_RXS_LSB 16
`define HRFP_SIZE_MASK    32'h00FF_FFFF
`define HRFP_SIZE_RST     32'h0010_1010
`define HRFP_ZERO_WORD    32'h0000_0000

`endif

// ### verilog/hrfp_pkg.sv
// Shared types and address helpers of the host port.
`include "hrfp_defines.svh"
package hrfp_pkg;
    typedef logic [31:0] hrfp_word_t;
    typedef logic [15:0] hrfp_half_t;
    typedef logic [7:0]  hrfp_addr_t;

    typedef enum logic [1:0] {
        HRFP_HS_IDLE = 2'b00,
        HRFP_HS_LO   = 2'b01,
        HRFP_HS_HI   = 2'b10
    } hrfp_hstate_t;

    // True for every location that is not a reserved register.
    function automatic logic hrfp_mapped(input hrfp_addr_t a);
        hrfp_addr_t d;
        d = {a[7:2], 2'b00};
        return (d[`HRFP_SEL_HI] == 1'b0) ||
               ((d >= `HRFP_A_RXS_POP) && (d <= `HRFP_A_LAST));
    endfunction

    // Bits that the host may set to one; reserved bits are zero.
    function automatic hrfp_word_t hrfp_wmask(input hrfp_addr_t a);
        hrfp_addr_t d;
        d = {a[7:2], 2'b00};
        case (d)
            `HRFP_A_CTRL: return `HRFP_CTRL_MASK;
            `HRFP_A_STAT: return `HRFP_STAT_MASK;
            `HRFP_A_SIZE: return `HRFP_SIZE_MASK;
            default:      return ~`HRFP_ZERO_WORD;
        endcase
    endfunction
endpackage

// ### verilog/hrfp_if.sv
// Sixteen-bit host bus between the host end and the device end.
interface hrfp_if
    import hrfp_pkg::*;
();
    logic       hb_rd;
    logic       hb_wr;
    hrfp_addr_t hb_addr;
    hrfp_half_t hb_wdata;
    hrfp_half_t hb_rdata;
    logic       hb_rvalid;

    modport dev (
        input  hb_rd,
        input  hb_wr,
        input  hb_addr,
        input  hb_wdata,
        output hb_rdata,
        output hb_rvalid
    );

    modport host (
        output hb_rd,
        output hb_wr,
        output hb_addr,
        output hb_wdata,
        input  hb_rdata,
        input  hb_rvalid
    );
endinterface

// ### verilog/hrfp_fifo.sv
// Queue with a size limit input, used for each host queue; software sets it for all but transmit status, fixed at full depth.
module hrfp_fifo #(
    parameter int W  = 32,
    parameter int AW = 4
) (
    input  wire logic          clk,
    input  wire logic          ce,
    input  wire logic          sys_rst,
    input  wire logic          flush,
    input  wire logic [AW:0]   limit,
    input  wire logic          push,
    input  wire logic [W-1:0]  din,
    input  wire logic          pop,
    output logic      [W-1:0]  head,
    output logic               empty,
    output logic               full
);
    localparam logic [AW:0] DEPTH = (AW+1)'(2**AW);

    logic [W-1:0]  mem [2**AW];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0]   cnt_r;
    logic          do_push;
    logic          do_pop;

    // [R12] size limit
    assign full    = (cnt_r == DEPTH) || (cnt_r >= limit);
    assign empty   = (cnt_r == '0);
    assign do_push = push && !full;
    assign do_pop  = pop && !empty;
    assign head    = mem[rd_ptr_r];

    always_ff @(posedge clk) begin
        if (ce && do_push) begin
            mem[wr_ptr_r] <= din;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || (ce && flush)) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else if (ce) begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (do_push && !do_pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (do_pop && !do_push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// ### verilog/hrfp_host.sv
// Host end: splits 32-bit commands into pairs of 16-bit transfers.
module hrfp_host
    import hrfp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       ce,
    input  wire logic       sys_rst,
    hrfp_if.host            hb,
    input  wire logic       cmd_valid,
    input  wire logic       cmd_write,
    input  wire hrfp_addr_t cmd_addr,
    input  wire hrfp_word_t cmd_wdata,
    output logic            cmd_ready,
    output logic            rsp_valid,
    output hrfp_word_t      rsp_data,
    output logic            rsp_err
);
    hrfp_hstate_t state_r;
    logic         write_r;
    logic         rd_r;
    logic         wr_r;
    hrfp_addr_t   addr_r;
    hrfp_word_t   wdata_r;
    hrfp_half_t   wout_r;

    assign cmd_ready   = (state_r == HRFP_HS_IDLE);
    assign hb.hb_rd    = rd_r;
    assign hb.hb_wr    = wr_r;
    assign hb.hb_addr  = addr_r;
    assign hb.hb_wdata = wout_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r   <= HRFP_HS_IDLE;
            write_r   <= 1'b0;
            rd_r      <= 1'b0;
            wr_r      <= 1'b0;
            addr_r    <= '0;
            wdata_r   <= '0;
            wout_r    <= '0;
            rsp_valid <= 1'b0;
            rsp_data  <= '0;
            rsp_err   <= 1'b0;
        end else if (ce) begin
            rd_r      <= 1'b0;
            wr_r      <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_err   <= 1'b0;
            case (state_r)
                HRFP_HS_IDLE: begin
                    if (cmd_valid) begin
                        // [R10] refuse reserved registers
                        if (!hrfp_mapped(cmd_addr)) begin
                            rsp_valid <= 1'b1;
                            rsp_err   <= 1'b1;
                        end else begin
                            // [R9] reserved bits zero
                            wdata_r <= cmd_wdata & hrfp_wmask(cmd_addr);
                            wout_r  <= cmd_wdata[15:0] &
                                       hrfp_half_t'(hrfp_wmask(cmd_addr));
                            write_r <= cmd_write;
                            addr_r  <= {cmd_addr[7:2], 2'b00};
                            rd_r    <= !cmd_write;
                            wr_r    <= cmd_write;
                            state_r <= HRFP_HS_LO;
                        end
                    end
                end
                HRFP_HS_LO: begin
                    // [R2] second half follows
                    if (write_r) begin
                        addr_r[`HRFP_HALF_BIT] <= 1'b1;
                        wout_r  <= wdata_r[31:16];
                        wr_r    <= 1'b1;
                        state_r <= HRFP_HS_HI;
                    end else if (hb.hb_rvalid) begin
                        rsp_data[15:0] <= hb.hb_rdata;
                        addr_r[`HRFP_HALF_BIT] <= 1'b1;
                        rd_r    <= 1'b1;
                        state_r <= HRFP_HS_HI;
                    end
                end
                HRFP_HS_HI: begin
                    if (write_r) begin
                        rsp_valid <= 1'b1;
                        state_r   <= HRFP_HS_IDLE;
                    end else if (hb.hb_rvalid) begin
                        rsp_data[31:16] <= hb.hb_rdata;
                        rsp_valid <= 1'b1;
                        state_r   <= HRFP_HS_IDLE;
                    end
                end
                default: state_r <= HRFP_HS_IDLE;
            endcase
        end
    end
endmodule

// ### verification/hrfp_props.sv
// Assertions on the host bus that joins the host end and the device end.
module hrfp_props
    import hrfp_pkg::*;
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       hb_rd,
    input wire logic       hb_wr,
    input wire hrfp_addr_t hb_addr,
    input wire hrfp_half_t hb_rdata,
    input wire logic       hb_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Bus timing and pairing
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    rd_answer_a:
    assert property (hb_rd |=> hb_rvalid) else $error("read not answered");
    rvalid_cause_a:
    assert property (hb_rvalid |-> $past(hb_rd))
        else $error("answer without read");
    strobe_excl_a:
    assert property (!(hb_rd && hb_wr)) else $error("read and write at once");
    rd_pair_a:
    assert property (hb_rd && !hb_addr[1] |-> ##2 hb_rd &&
        hb_addr == ($past(hb_addr, 2) | 8'h02)) else $error("read half lost");
    wr_pair_a:
    assert property (hb_wr && !hb_addr[1] |=> hb_wr &&
        hb_addr == ($past(hb_addr) | 8'h02)) else $error("write half lost");
    hi_after_lo_a:
    assert property (hb_rd && hb_addr[1] |->
        $past(hb_rd, 2) && !$past(hb_addr[1], 2))
        else $error("high half without low");
    no_reserved_a:
    assert property ((hb_rd || hb_wr) |-> hb_addr < 8'hA0)
        else $error("reserved address on bus");
    wo_zero_a:
    assert property (hb_rd && hb_addr[7:6] == 2'h1 |=> hb_rdata == 16'h0000)
        else $error("write-only port read nonzero");
    rdata_hold_a:
    assert property (!hb_rvalid |-> $stable(hb_rdata))
        else $error("read data moved");
endmodule

// ### verification/testbench.sv
// Self-checking bench joining the host end and the device end.
`include "hrfp_defines.svh"
module testbench
    import hrfp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Identification value is arbitrary.
    localparam hrfp_word_t TB_ID = 32'h0000_1234;
    logic       clk = 1'b0, sys_rst = 1'b1, txd_ready = 1'b0;
    logic       link_ok = 1'b1, fault = 1'b0, err_evt = 1'b0;
    logic       rx_drop = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0;
    logic [2:0] qv = 3'b000;
    logic [2:0] rdy;
    hrfp_word_t qd = 32'h0000_0000, cmd_wdata = 32'h0000_0000;
    hrfp_addr_t cmd_addr = 8'h00;
    logic       txd_valid, soft_rst, cmd_ready, rsp_valid, rsp_err, last_err;
    hrfp_word_t txd_data, rsp_data, rq;
    logic [7:0] ctrl_imm;
    int         miscompares = 0, checks_done = 0, srst_n = 0;
    hrfp_if i_hrfp_if ();
    hrfp_dev #(.ID_VAL(TB_ID)) i_hrfp_dev (.clk(clk), .ce(1'b1),
        .sys_rst(sys_rst), .hb(i_hrfp_if.dev), .rxs_valid(qv[0]),
        .rxs_data(qd), .rxs_ready(rdy[0]), .rxd_valid(qv[1]), .rxd_data(qd),
        .rxd_ready(rdy[1]), .txs_valid(qv[2]), .txs_data(qd),
        .txs_ready(rdy[2]), .txd_valid(txd_valid), .txd_data(txd_data),
        .txd_ready(txd_ready), .link_ok(link_ok), .fault(fault),
        .err_evt(err_evt), .rx_drop(rx_drop), .soft_rst(soft_rst),
        .ctrl_imm(ctrl_imm), .ctrl_gen());
    hrfp_host i_hrfp_host (.clk(clk), .ce(1'b1), .sys_rst(sys_rst),
        .hb(i_hrfp_if.host), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err));
    hrfp_props i_props (.clk(clk), .sys_rst(sys_rst),
        .hb_rd(i_hrfp_if.hb_rd), .hb_wr(i_hrfp_if.hb_wr),
        .hb_addr(i_hrfp_if.hb_addr), .hb_rdata(i_hrfp_if.hb_rdata),
        .hb_rvalid(i_hrfp_if.hb_rvalid));

    always #10 clk = ~clk;
    always @(posedge clk) if (soft_rst === 1'b1) srst_n++;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input hrfp_word_t got, input hrfp_word_t exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input hrfp_addr_t a,
                       input hrfp_word_t d);
        int n;
        n = 0;
        cmd_write <= w;
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        while (rsp_valid !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) begin
            miscompares++;
            $display("MISMATCH %0t no response", $time);
        end
        rq = rsp_data;
        last_err = rsp_err;
    endtask
    task automatic rd(input hrfp_addr_t a);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic push(input int k, input hrfp_word_t d);
        qd <= d;
        qv[k] <= 1'b1;
        @(posedge clk);
        qv <= 3'b000;
        @(posedge clk);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(`HRFP_A_SIZE);
        chk(rq, 32'h0010_1010);
        bus(1'b1, `HRFP_A_ID, 32'hFFFF_FFFF);
        rd(`HRFP_A_ID);
        chk(rq, TB_ID);
        rd(8'hA0);
        chk({31'h0, last_err}, 32'h0000_0001);
    endtask
    task automatic t_status;
        hrfp_addr_t b;
        for (int k = 0; k < 3; k += 2) begin
            b = (k == 0) ? `HRFP_A_RXS_POP : `HRFP_A_TXS_POP;
            push(k, 32'hA5A5_0001 + k);
            push(k, 32'h5A5A_0002 + k);
            rd(b + 8'h04);
            chk(rq, 32'hA5A5_0001 + k);
            rd(b + 8'h04);
            chk(rq, 32'hA5A5_0001 + k);
            rd(b);
            chk(rq, 32'hA5A5_0001 + k);
            rd(b);
            chk(rq, 32'h5A5A_0002 + k);
            rd(b + 8'h04);
            chk(rq, 32'h0000_0000);
        end
    endtask
    task automatic t_rxd;
        for (int i = 0; i < 3; i++) push(1, 32'h1234_0000 + i);
        bus(1'b1, 8'h00, 32'hDEAD_BEEF);
        for (int i = 0; i < 3; i++) begin
            rd(8'(i * 28));
            chk(rq, 32'h1234_0000 + i);
        end
    endtask
    task automatic t_txd;
        bus(1'b1, 8'h40, 32'hCAFE_0001);
        bus(1'b1, 8'h7C, 32'hCAFE_0002);
        rd(8'h40);
        chk(rq, 32'h0000_0000);
        chk(txd_data, 32'hCAFE_0001);
        txd_ready <= 1'b1;
        @(posedge clk);
        txd_ready <= 1'b0;
        @(posedge clk);
        chk(txd_data, 32'hCAFE_0002);
        txd_ready <= 1'b1;
        @(posedge clk);
        txd_ready <= 1'b0;
        @(posedge clk);
        chk({31'h0, txd_valid}, 32'h0000_0000);
    endtask
    task automatic t_stat;
        err_evt <= 1'b1;
        rx_drop <= 1'b1;
        fault <= 1'b1;
        link_ok <= 1'b0;
        @(posedge clk);
        err_evt <= 1'b0;
        fault <= 1'b0;
        link_ok <= 1'b1;
        repeat (2) @(posedge clk);
        rx_drop <= 1'b0;
        rd(`HRFP_A_STAT);
        chk(rq, 32'h0003_0005);
        rd(`HRFP_A_STAT);
        chk(rq, 32'h0000_0003);
        bus(1'b1, `HRFP_A_STAT, 32'h0000_0000);
        rd(`HRFP_A_STAT);
        chk(rq, 32'h0000_0003);
        bus(1'b1, `HRFP_A_STAT, 32'h0000_0001);
        rd(`HRFP_A_STAT);
        chk(rq, 32'h0000_0002);
    endtask
    task automatic t_srst;
        bus(1'b1, `HRFP_A_SIZE, 32'hFF04_0801);
        rd(`HRFP_A_SIZE);
        chk(rq, 32'h0004_0801);
        bus(1'b1, `HRFP_A_CTRL, 32'hFFCD_AB00);
        push(1, 32'h7777_0000);
        chk({31'h0, rdy[1]}, 32'h0000_0000);
        bus(1'b1, `HRFP_A_CTRL, 32'h00CD_AB01);
        rd(`HRFP_A_CTRL);
        chk(rq, 32'h0000_AB00);
        chk(32'(srst_n), 32'h0000_0001);
        chk({24'h0, ctrl_imm}, 32'h0000_00AB);
        rd(`HRFP_A_SIZE);
        chk(rq, 32'h0010_1010);
        rd(8'h00);
        chk(rq, 32'h0000_0000);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_status();
        t_rxd();
        t_txd();
        t_stat();
        t_srst();
        finish_test();
    end
endmodule
